// ---- hdl/unit_status_pkg.sv ----
// Package with status word layout, carriers and reset values for the unit status block
package unit_status_pkg;

  // ---------------------------------------------------------------------------
  // Status word bit positions
  // ---------------------------------------------------------------------------
  localparam int unsigned WORD_MSB          = 15;  // Top bit of the upper half
  localparam int unsigned WORD_LSB          = 4;   // Lowest bit this block drives
  localparam int unsigned BIT_PORT1_FAULT   = 4;   // Serial port one fault
  localparam int unsigned BIT_PORT2_FAULT   = 5;   // Serial port two fault
  localparam int unsigned BIT_BATTERY_LOW   = 6;   // Backup battery alarm
  localparam int unsigned BIT_PROGRAM_RUN   = 7;   // Resident program executing
  localparam int unsigned BIT_ERROR_NEW     = 8;   // Error code is new (1) or old (0)
  localparam int unsigned BIT_HOST_INT_FAIL = 9;   // Host interrupt could not be delivered
  localparam int unsigned BIT_UNUSED_LO     = 10;  // First unused bit
  localparam int unsigned BIT_UNUSED_HI     = 13;  // Last unused bit
  localparam int unsigned BIT_READ_REQUEST  = 14;  // Host block read requested
  localparam int unsigned BIT_WRITE_REQUEST = 15;  // Host block write requested

  // ---------------------------------------------------------------------------
  // Field values and reset values
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  UNUSED_VALUE      = 4'h0;    // Unused bits always read zero
  localparam logic [5:0]  SAMPLED_RESET     = 6'h00;   // Bits 04 to 09 after reset
  localparam logic [11:0] STATUS_RESET      = 12'h000; // Whole upper half after reset
  localparam int unsigned REQUEST_CHANNELS  = 2;       // Read request and write request

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  // Live conditions inside the unit, presented to the host at each refresh
  typedef struct packed {
    logic error_code_new;   // Error code being read arose after last run start
    logic program_running;  // Resident program executing
    logic battery_low;      // Battery voltage dropped or battery missing
    logic port2_fault;      // Port two parity error, overrun and the like
    logic port1_fault;      // Port one parity error, overrun and the like
  } unit_sense_s;

  // Block transfer events, one bit per request channel (0 read, 1 write)
  typedef struct packed {
    logic [REQUEST_CHANNELS-1:0] command;  // Unit ran its push or pull block command
    logic [REQUEST_CHANNELS-1:0] taken;    // Host ran the matching block instruction
  } block_event_s;

endpackage : unit_status_pkg

// ---- hdl/block_request_flag.sv ----
// One block transfer request flag: set by a unit command, cleared after the host serves it
`timescale 1ns/1ps
module block_request_flag (
  input  wire logic clk_i,      // Unit clock
  input  wire logic rst_n_i,    // Synchronised reset, active low
  input  wire logic ce_i,       // Clock enable, freezes state when low
  input  wire logic command_i,  // Unit block command executed, one-cycle pulse
  input  wire logic taken_i,    // Host block instruction executed, one-cycle pulse
  input  wire logic refresh_i,  // Host I/O refresh, one-cycle pulse
  output logic      flag_o      // Request flag as shown to the host
);

  typedef enum logic [1:0] {
    FLAG_CLEAR,
    FLAG_SET,
    FLAG_TAKEN
  } flag_state_e;

  flag_state_e state;
  flag_state_e next_state;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // A new command always wins over a pending clear, so no request is lost
  always_comb begin
    next_state = state;
    unique case (state)
      FLAG_CLEAR: begin
        if (command_i) begin
          next_state = FLAG_SET;
        end
      end
      FLAG_SET: begin
        if (taken_i && !command_i) begin
          next_state = FLAG_TAKEN;
        end
      end
      FLAG_TAKEN: begin
        if (command_i) begin
          next_state = FLAG_SET;
        end else if (refresh_i) begin
          next_state = FLAG_CLEAR;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= FLAG_CLEAR;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // Flag stays up while the host transfer is in flight and until the refresh
  assign flag_o = (state != FLAG_CLEAR);

endmodule : block_request_flag

// ---- hdl/unit_status_word_handshake.sv ----
// Upper half of the unit status word and its block transfer handshake with the host
`timescale 1ns/1ps
module unit_status_word_handshake (
  input  wire logic                        REF_CLK_I,             // 50 MHz unit clock
  input  wire logic                        RST_N_I,               // Async reset, active low
  input  wire logic                        CE_I,                  // Clock enable
  input  wire logic                        IO_REFRESH_I,          // Host refresh, pulse
  input  wire unit_status_pkg::unit_sense_s SENSE_I,              // Live unit conditions
  input  wire logic                        HOST_INT_REQUEST_I,    // Unit asks to interrupt
  input  wire logic                        HOST_INT_STOPPED_I,    // Stop-interrupt setting
  input  wire logic                        PUSH_BLOCK_CMD_I,      // Push block command, pulse
  input  wire logic                        PULL_BLOCK_CMD_I,      // Pull block command, pulse
  input  wire logic                        HOST_BLOCK_READ_I,     // Host block read done
  input  wire logic                        HOST_BLOCK_WRITE_I,    // Host block write done
  output logic [15:4]                      STATUS_WORD_O,         // Status bits 15 to 04
  output logic                             HOST_INTERRUPT_O       // Host interrupt bit
);

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  // Reset asserts at once but leaves on a clock edge, so no flop sees a runt release
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ---------------------------------------------------------------------------
  // Qualified events
  // ---------------------------------------------------------------------------
  logic refresh;
  logic int_request;
  unit_status_pkg::block_event_s blk;

  assign refresh     = CE_I && IO_REFRESH_I;
  assign int_request = CE_I && HOST_INT_REQUEST_I;

  // Channel 0 is the read request, channel 1 the write request
  always_comb begin
    blk.command = {PULL_BLOCK_CMD_I, PUSH_BLOCK_CMD_I};
    blk.taken   = {HOST_BLOCK_WRITE_I, HOST_BLOCK_READ_I};
  end

  // ---------------------------------------------------------------------------
  // Host interrupt path
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    INT_IDLE,
    INT_ARMED,
    INT_ON
  } int_state_e;

  int_state_e int_state;
  int_state_e next_int_state;
  logic       int_fail;
  logic       next_int_fail;

  // The interrupt bit follows the host cycle: it rises at one refresh and falls at the
  // next, so the host program sees it for exactly one scan whatever the unit does meanwhile
  always_comb begin
    next_int_state = int_state;
    next_int_fail  = int_fail;
    if (int_request && HOST_INT_STOPPED_I) begin
      next_int_fail = 1'b1;
    end else if (int_request) begin
      next_int_fail = 1'b0;
    end
    unique case (int_state)
      INT_IDLE: begin
        if (int_request) begin
          next_int_state = INT_ARMED;
        end
      end
      INT_ARMED: begin
        if (refresh) begin
          next_int_state = INT_ON;
        end
      end
      INT_ON: begin
        if (refresh) begin
          next_int_state = INT_IDLE;
        end
      end
    endcase
  end

  // Interrupt registers
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      int_state <= INT_IDLE;
      int_fail  <= 1'b0;
    end else if (CE_I) begin
      int_state <= next_int_state;
      int_fail  <= next_int_fail;
    end
  end

  assign HOST_INTERRUPT_O = (int_state == INT_ON);

  // ---------------------------------------------------------------------------
  // Sampled status bits 04 to 09
  // ---------------------------------------------------------------------------
  logic [5:0] sampled;
  logic [5:0] next_sampled;

  // The host only reads the word at refresh, so the bits are frozen between refreshes
  // to give it one consistent snapshot rather than a word that tears mid-read
  always_comb begin
    next_sampled = sampled;
    if (refresh) begin
      next_sampled = {int_fail,
                      SENSE_I.error_code_new,
                      SENSE_I.program_running,
                      SENSE_I.battery_low,
                      SENSE_I.port2_fault,
                      SENSE_I.port1_fault};
    end
  end

  // Snapshot register
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sampled <= unit_status_pkg::SAMPLED_RESET;
    end else if (CE_I) begin
      sampled <= next_sampled;
    end
  end

  // ---------------------------------------------------------------------------
  // Block transfer request flags
  // ---------------------------------------------------------------------------
  logic [unit_status_pkg::REQUEST_CHANNELS-1:0] request;

  // One flag per direction; both follow the same set, serve, clear sequence
  for (genvar ch = 0; ch < unit_status_pkg::REQUEST_CHANNELS; ch++) begin : g_request
    block_request_flag u_flag (
      .clk_i     (REF_CLK_I),
      .rst_n_i   (rst_n),
      .ce_i      (CE_I),
      .command_i (blk.command[ch]),
      .taken_i   (blk.taken[ch]),
      .refresh_i (IO_REFRESH_I),
      .flag_o    (request[ch])
    );
  end

  // ---------------------------------------------------------------------------
  // Status word assembly
  // ---------------------------------------------------------------------------
  // Request flags are already registered; sampled bits come from the snapshot
  always_comb begin
    STATUS_WORD_O = unit_status_pkg::STATUS_RESET;
    STATUS_WORD_O[unit_status_pkg::BIT_HOST_INT_FAIL:unit_status_pkg::BIT_PORT1_FAULT]
      = sampled;
    STATUS_WORD_O[unit_status_pkg::BIT_UNUSED_HI:unit_status_pkg::BIT_UNUSED_LO]
      = unit_status_pkg::UNUSED_VALUE;
    STATUS_WORD_O[unit_status_pkg::BIT_READ_REQUEST]  = request[0];
    STATUS_WORD_O[unit_status_pkg::BIT_WRITE_REQUEST] = request[1];
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_port1_fault: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    refresh |=> STATUS_WORD_O[4] == $past(SENSE_I.port1_fault))
    else $error("Port one fault bit does not follow the port");

  a_port2_fault: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    refresh |=> STATUS_WORD_O[5] == $past(SENSE_I.port2_fault))
    else $error("Port two fault bit does not follow the port");

  a_battery_alarm: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    refresh |=> STATUS_WORD_O[6] == $past(SENSE_I.battery_low))
    else $error("Battery bit does not follow the battery");

  a_program_run: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    refresh |=> STATUS_WORD_O[7] == $past(SENSE_I.program_running))
    else $error("Run bit does not follow the program");

  a_error_new: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    refresh |=> STATUS_WORD_O[8] == $past(SENSE_I.error_code_new))
    else $error("Error code age bit is wrong");

  a_int_fail_set: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (int_request && HOST_INT_STOPPED_I) ##1 (refresh && !int_request)
      |=> STATUS_WORD_O[9])
    else $error("Interrupt fail bit not shown after blocked request");

  // The bit may only hold while no refresh is taken, and must drop on the first one
  a_int_one_cycle: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    HOST_INTERRUPT_O |=> HOST_INTERRUPT_O == !$past(refresh))
    else $error("Interrupt bit not held for exactly one host cycle");

  // An armed request turns the bit on at the very next refresh
  a_int_armed_on: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (int_state == INT_ARMED && refresh) |=> HOST_INTERRUPT_O)
    else $error("Interrupt bit did not rise at the refresh after a request");

  a_int_rise_refresh: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    $changed(HOST_INTERRUPT_O) |-> $past(refresh))
    else $error("Interrupt bit moved outside a refresh");

  a_read_req_set: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (CE_I && PUSH_BLOCK_CMD_I) |=> STATUS_WORD_O[14])
    else $error("Push command did not raise the read request");

  a_read_req_clear: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    $fell(STATUS_WORD_O[14]) |-> $past(refresh))
    else $error("Read request cleared outside a refresh");

  a_write_req_set: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (CE_I && PULL_BLOCK_CMD_I) |=> STATUS_WORD_O[15])
    else $error("Pull command did not raise the write request");

  a_write_req_clear: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    $fell(STATUS_WORD_O[15]) |-> $past(refresh))
    else $error("Write request cleared outside a refresh");

  a_read_served: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (CE_I && HOST_BLOCK_READ_I && STATUS_WORD_O[14] && !PUSH_BLOCK_CMD_I)
      ##1 (refresh && !PUSH_BLOCK_CMD_I) |=> !STATUS_WORD_O[14])
    else $error("Read request not cleared at refresh after host read");

  a_write_served: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (CE_I && HOST_BLOCK_WRITE_I && STATUS_WORD_O[15] && !PULL_BLOCK_CMD_I)
      ##1 (refresh && !PULL_BLOCK_CMD_I) |=> !STATUS_WORD_O[15])
    else $error("Write request not cleared at refresh after host write");

  a_unused_zero: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    STATUS_WORD_O[13:10] == 4'h0 && $stable(STATUS_WORD_O[13:10]))
    else $error("Unused status bits not zero");

  // Between refreshes the snapshot must not move, so the host never sees a torn word
  a_sampled_hold: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    !refresh |=> $stable(STATUS_WORD_O[9:4]))
    else $error("Sampled status bits moved between refreshes");

  // A later delivered request lifts the fail indication at the next snapshot
  a_int_fail_clear: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (int_request && !HOST_INT_STOPPED_I) ##1 (refresh && !int_request)
      |=> !STATUS_WORD_O[9])
    else $error("Interrupt fail bit not cleared after a delivered request");

  // A clear flag may only rise on a command, so a stray host pulse cannot fake a request
  a_read_req_idle: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (!STATUS_WORD_O[14] && !(CE_I && PUSH_BLOCK_CMD_I)) |=> !STATUS_WORD_O[14])
    else $error("Read request rose without a push command");

  // Same guard on the write side
  a_write_req_idle: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (!STATUS_WORD_O[15] && !(CE_I && PULL_BLOCK_CMD_I)) |=> !STATUS_WORD_O[15])
    else $error("Write request rose without a pull command");

  // A low clock enable must hold every output, or the host would see a moving word
  a_ce_freeze: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    !CE_I |=> $stable(STATUS_WORD_O) && $stable(HOST_INTERRUPT_O))
    else $error("Outputs moved while the clock enable was low");

endmodule : unit_status_word_handshake

// ---- bench/host_cpu_model.sv ----
// Behavioural host controller: refresh pulses and block instructions that answer request flags
`timescale 1ns/1ps
module host_cpu_model #(
  parameter int REFRESH_PERIOD = 5  // Unit clock cycles per host I/O refresh
) (
  input  wire logic       clk_i,        // Unit clock
  input  wire logic       rst_n_i,      // Reset, active low
  input  wire logic [3:0] serve_wait_i, // Cycles the host dawdles before serving
  input  wire logic [1:0] request_i,    // Request flags seen, 0 read and 1 write
  output logic            refresh_o,    // Host I/O refresh pulse
  output logic [1:0]      block_op_o    // Block instruction done, 0 read and 1 write
);
  // ---------------------------------------------------------------------------
  // Refresh timer and request servicing
  // ---------------------------------------------------------------------------
  logic [3:0] phase;
  logic [3:0] wait_cnt [2];
  logic [1:0] served;

  // Served stays set until the flag drops, so one request gets exactly one instruction
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= 4'h0;
      refresh_o <= 1'b0;
      block_op_o <= 2'h0;
      served <= 2'h0;
      wait_cnt[0] <= 4'h0;
      wait_cnt[1] <= 4'h0;
    end else begin
      refresh_o <= (phase == 4'(REFRESH_PERIOD - 1));
      phase <= (phase == 4'(REFRESH_PERIOD - 1)) ? 4'h0 : phase + 4'h1;
      for (int ch = 0; ch < 2; ch++) begin
        block_op_o[ch] <= 1'b0;
        if (request_i[ch] !== 1'b1) begin
          served[ch] <= 1'b0;
          wait_cnt[ch] <= serve_wait_i;
        end else if (!served[ch]) begin
          if (wait_cnt[ch] == 4'h0) begin
            block_op_o[ch] <= 1'b1;
            served[ch] <= 1'b1;
          end else begin
            wait_cnt[ch] <= wait_cnt[ch] - 4'h1;
          end
        end
      end
    end
  end
endmodule : host_cpu_model

// ---- bench/test_unit_status_word_handshake.sv ----
// Self-checking bench for the unit status word and its block transfer handshake
`timescale 1ns/1ps
module test_unit_status_word_handshake;
  // ---------------------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------------------
  logic                         clk = 1'b0;
  logic                         rst_n = 1'b0;
  logic                         ce = 1'b1;
  unit_status_pkg::unit_sense_s sense = '0;
  logic                         int_stop = 1'b0;
  logic [2:0]                   events = 3'h0;  // 0 push, 1 pull, 2 interrupt request
  logic [3:0]                   serve_wait = 4'h0;
  logic                         refresh;
  logic [1:0]                   host_op;
  logic [15:4]                  status;
  logic                         host_int;
  int                           errors = 0;
  int                           comparisons = 0;
  int                           cycles = 0;

  always #10 clk = ~clk;

  unit_status_word_handshake u_unit_status_word_handshake (
    .REF_CLK_I          (clk),
    .RST_N_I            (rst_n),
    .CE_I               (ce),
    .IO_REFRESH_I       (refresh),
    .SENSE_I            (sense),
    .HOST_INT_REQUEST_I (events[2]),
    .HOST_INT_STOPPED_I (int_stop),
    .PUSH_BLOCK_CMD_I   (events[0]),
    .PULL_BLOCK_CMD_I   (events[1]),
    .HOST_BLOCK_READ_I  (host_op[0]),
    .HOST_BLOCK_WRITE_I (host_op[1]),
    .STATUS_WORD_O      (status),
    .HOST_INTERRUPT_O   (host_int)
  );

  host_cpu_model u_host_cpu_model (
    .clk_i        (clk),
    .rst_n_i      (rst_n),
    .serve_wait_i (serve_wait),
    .request_i    (status[15:14]),
    .refresh_o    (refresh),
    .block_op_o   (host_op)
  );

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] expected);
    comparisons++;
    if (seen !== expected) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // One-cycle pulse on an event input, launched and dropped on rising edges
  task automatic pulse(input int idx);
    @(posedge clk);
    events[idx] <= 1'b1;
    @(posedge clk);
    events[idx] <= 1'b0;
  endtask : pulse

  // Return at the edge where the design takes a refresh, then let outputs settle
  task automatic wait_refresh();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (refresh !== 1'b1 && n < 40);
    if (n >= 40) check(12'h0, 12'hfff);
    @(negedge clk);
  endtask : wait_refresh

  // Return after the edge that takes the host's block instruction on a channel
  task automatic wait_host(input int ch);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (host_op[ch] !== 1'b1 && n < 40);
    if (n >= 40) check(12'h0, 12'hfff);
    @(negedge clk);
  endtask : wait_host

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    check(status, 12'h000);
    check(12'(host_int), 12'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    $display("test reset done");

    // Each live condition alone, so a swapped bit shows up
    for (int b = 0; b < 5; b++) begin
      @(posedge clk);
      sense <= unit_status_pkg::unit_sense_s'(5'h01 << b);
      wait_refresh();
      check(12'(status[8:4]), 12'(5'h01 << b));
      check(12'(status[13:10]), 12'h0);
    end
    @(posedge clk);
    sense <= '0;
    $display("test sense bits done");

    // Blocked interrupt: fail flag and one refresh period of interrupt bit
    @(posedge clk);
    int_stop <= 1'b1;
    pulse(2);
    wait_refresh();
    check(12'(status[9]), 12'h1);
    check(12'(host_int), 12'h1);
    wait_refresh();
    check(12'(host_int), 12'h0);
    @(posedge clk);
    int_stop <= 1'b0;
    pulse(2);
    wait_refresh();
    check(12'(status[9]), 12'h0);
    check(12'(host_int), 12'h1);
    wait_refresh();
    check(12'(host_int), 12'h0);
    $display("test interrupt fail done");

    // Clock enable low: a push command is not taken
    @(posedge clk);
    ce <= 1'b0;
    pulse(0);
    ce <= 1'b1;
    @(negedge clk);
    check(12'(status[14]), 12'h0);
    $display("test clock enable done");

    // Push then pull, with a prompt host and a slow one
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      serve_wait <= (k < 2) ? 4'h0 : 4'h6;
      pulse(k % 2);
      @(negedge clk);
      check(12'(status[14 + k % 2]), 12'h1);
      wait_host(k % 2);
      check(12'(status[14 + k % 2]), 12'h1);
      wait_refresh();
      check(12'(status[15:14]), 12'h0);
    end
    $display("test block handshake done");
    give_verdict();
  end
endmodule : test_unit_status_word_handshake
